// ---- rtl/emr_pkg.sv ----
/*
 * Constants, register map and types of the external memory read sequencer.
 * Assumes one core clock, which also serves as the timing clock, and a plain
 * register port driven by a master on the same clock.
 */
package emr_pkg;

    // Register byte addresses.
    localparam logic [7:0] EMR_CFG_OFS = 8'h00;
    localparam logic [7:0] EMR_ADDR_OFS = 8'h04;
    localparam logic [7:0] EMR_CTRL_OFS = 8'h08;
    localparam logic [7:0] EMR_STAT_OFS = 8'h0C;
    localparam logic [7:0] EMR_DATA_OFS = 8'h10;
    localparam logic [7:0] EMR_WAIT_OFS = 8'h14;

    // Field positions inside the configuration word.
    localparam int EMR_CFG_LEAD_LSB = 0;
    localparam int EMR_CFG_ACT_LSB = 2;
    localparam int EMR_CFG_TRAIL_LSB = 5;
    localparam int EMR_CFG_RDYEN_BIT = 7;
    localparam int EMR_CFG_RDYMODE_BIT = 8;
    localparam int EMR_CFG_WIDTH = 9;

    // Control and status bit positions.
    localparam int EMR_CTRL_START_BIT = 0;
    localparam int EMR_CTRL_CLRDONE_BIT = 1;
    localparam int EMR_STAT_BUSY_BIT = 0;
    localparam int EMR_STAT_DONE_BIT = 1;

    // Reset values.
    localparam logic [8:0] EMR_CFG_RESET = 9'h007;
    localparam logic [18:0] EMR_ADDR_RESET = 19'h00000;

    // Timing counts, in timing clock cycles.
    localparam logic [3:0] EMR_ASYNC_ADVANCE = 4'h2;
    localparam logic [1:0] EMR_MIN_LEAD = 2'h1;

    // Bus widths.
    localparam int EMR_AW = 19;
    localparam int EMR_DW = 16;

    // Per-zone timing setting carried as one word.
    typedef struct packed {
        logic ready_sync_select;
        logic ready_enable;
        logic [1:0] read_trail_cycles;
        logic [2:0] read_active_cycles;
        logic [1:0] read_lead_cycles;
    } emr_cfg_s;

    // Sequencer states.
    typedef enum logic [2:0] {
        EMR_IDLE,
        EMR_ALIGN,
        EMR_LEAD,
        EMR_ACTIVE,
        EMR_TRAIL
    } emr_state_e;

endpackage

// ---- rtl/emr_sync2.sv ----
/*
 * Two-stage synchroniser for inputs that come from outside the clock domain.
 * Assumes each bit is sampled independently; multi-bit data must be stable
 * around the sampling point, which the read setup time guarantees.
 */
`timescale 1ns/1ps
module emr_sync2 #(
    parameter int W = 1
) (
    input wire logic clk, // Sampling clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic [W-1:0] din, // Asynchronous input.
    output logic [W-1:0] dout // Synchronised output.
);

    logic [W-1:0] meta_q; // First stage, read only by the second stage.

    // Two flops in a row give metastability one full cycle to settle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end

endmodule

// ---- rtl/emr_read_seq.sv ----
/*
 * External memory read sequencer with ready-controlled wait states.
 * Assumes the core clock is the timing clock, the bus clock output runs at
 * half its rate, and software reaches the registers over a plain port.
 */
`timescale 1ns/1ps
module emr_read_seq (
    input wire logic core_clk, // Core and timing clock, 10 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic [7:0] reg_addr, // Register byte address.
    input wire logic [31:0] reg_wdata, // Register write data.
    input wire logic reg_wr, // Write strobe, one cycle.
    input wire logic reg_rd, // Read strobe, one cycle.
    output logic [31:0] reg_rdata, // Read data, valid the cycle after reg_rd.
    input wire logic wait_ready_in, // Ready from the external party, high means done.
    input wire logic [emr_pkg::EMR_DW-1:0] ext_data_in, // External read data bus.
    output logic bus_clock_out, // Output bus clock, half the timing clock.
    output logic zone_select_n, // Zone select, active low.
    output logic read_strobe_n, // Read strobe, active low.
    output logic write_strobe_n, // Write strobe, active low, never asserted here.
    output logic read_not_write, // Direction, high for read.
    output logic [emr_pkg::EMR_AW-1:0] ext_addr_bus // External address bus.
);
    import emr_pkg::*;

    emr_cfg_s cfg_q; // Timing configuration.
    logic [EMR_AW-1:0] addr_q; // Address for the next access.
    logic start_pend_q; // Access requested and not yet begun.
    logic done_q; // Sticky completion flag.
    logic [EMR_DW-1:0] data_q; // Data captured by the last access.
    logic [7:0] wait_cnt_q; // Wait states added by the last access.
    emr_state_e state_q; // Current sequencer state.
    emr_state_e state_d; // Next sequencer state.
    logic [3:0] cyc_q; // Cycles since access start, or into trail.
    logic ready_s; // Synchronised ready.
    logic [EMR_DW-1:0] data_s; // Synchronised read data.
    logic hold; // Ready sampled low, so the active period stretches.
    logic sample_now; // This cycle ends at a ready sample point.
    logic [3:0] lead_n; // Effective lead count.
    logic [3:0] last_act; // Index of the last active cycle.
    logic [3:0] samp_pt; // Index of the cycle that ends at the first sample.
    logic wr_ctrl; // Software writes the control register.

    // Lead below one is not a legal setting, so it is treated as one.
    function automatic logic [3:0] eff_lead(input emr_cfg_s c);
        eff_lead = (c.read_lead_cycles < EMR_MIN_LEAD) ? 4'h1 : {2'h0, c.read_lead_cycles};
    endfunction

    // Active length; with ready in use at least one active cycle is kept for sampling.
    function automatic logic [3:0] eff_active(input emr_cfg_s c);
        if (c.ready_enable && c.read_active_cycles == 3'h0) begin
            eff_active = 4'h1;
        end else begin
            eff_active = {1'b0, c.read_active_cycles};
        end
    endfunction

    // Both ready and data arrive from outside the core clock domain.
    // The two flops cost two cycles: ready is seen two cycles after the pin,
    // and read data needs at least three strobe-low cycles before capture,
    // so an active count below three returns data from before the strobe fell.
    emr_sync2 #(.W(1)) u_rdy_sync (
        .clk(core_clk),
        .rst_n(rst_n),
        .din(wait_ready_in),
        .dout(ready_s)
    );

    emr_sync2 #(.W(EMR_DW)) u_data_sync (
        .clk(core_clk),
        .rst_n(rst_n),
        .din(ext_data_in),
        .dout(data_s)
    );

    assign lead_n = eff_lead(cfg_q);
    assign last_act = 4'(lead_n + eff_active(cfg_q) - 4'h1);

    // Asynchronous mode looks two cycles earlier to cover its extra latency,
    // but never before the active period has begun.
    always_comb begin
        if (cfg_q.ready_sync_select && last_act >= 4'(lead_n + EMR_ASYNC_ADVANCE)) begin
            samp_pt = 4'(last_act - EMR_ASYNC_ADVANCE);
        end else if (cfg_q.ready_sync_select) begin
            samp_pt = lead_n;
        end else begin
            samp_pt = last_act;
        end
    end

    // Ready is only looked at when enabled; otherwise counts alone decide.
    assign sample_now = (state_q == EMR_ACTIVE) && cfg_q.ready_enable
        && (cyc_q == samp_pt);
    // A low sample freezes the counter, so the same point is sampled next cycle.
    assign hold = sample_now && !ready_s;

    // Control is a write-only strobe register with no storage of its own.
    assign wr_ctrl = reg_wr && (reg_addr == EMR_CTRL_OFS);

    // Next state of the sequencer.
    always_comb begin
        state_d = state_q;
        case (state_q)
            EMR_IDLE: begin
                if (start_pend_q) begin
                    // Bus clock low now means it rises with the next edge.
                    state_d = bus_clock_out ? EMR_ALIGN : EMR_LEAD;
                end
            end
            EMR_ALIGN: begin
                state_d = EMR_LEAD;
            end
            EMR_LEAD: begin
                if (cyc_q == 4'(lead_n - 4'h1)) begin
                    // Zero active cycles only happens with ready off; go to trail, or to idle when trail is zero.
                    if (eff_active(cfg_q) != 4'h0) begin
                        state_d = EMR_ACTIVE;
                    end else if (cfg_q.read_trail_cycles != 2'h0) begin
                        state_d = EMR_TRAIL;
                    end else begin
                        state_d = EMR_IDLE;
                    end
                end
            end
            EMR_ACTIVE: begin
                if (!hold && cyc_q == last_act) begin
                    // Strobe rises here; its bus clock phase is set by the
                    // parity of lead, active and wait cycles so far.
                    state_d = (cfg_q.read_trail_cycles != 2'h0) ? EMR_TRAIL : EMR_IDLE;
                end
            end
            // Trail keeps select low after the strobe has risen.
            EMR_TRAIL: begin
                if (cyc_q == 4'({2'h0, cfg_q.read_trail_cycles} - 4'h1)) begin
                    state_d = EMR_IDLE;
                end
            end
            default: begin
                state_d = EMR_IDLE;
            end
        endcase
    end

    // State register.
    // Reset lands in idle, so every control starts inactive.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= EMR_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Cycle counter; restarts at the access start and at the trail start.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_q <= 4'h0;
        end else if (state_d == EMR_LEAD && state_q != EMR_LEAD) begin
            cyc_q <= 4'h0;
        end else if (state_d == EMR_TRAIL && state_q != EMR_TRAIL) begin
            cyc_q <= 4'h0;
        end else if (hold) begin
            // A frozen count repeats the same sample point next cycle.
            cyc_q <= cyc_q;
        end else if (state_q != EMR_IDLE && state_q != EMR_ALIGN) begin
            cyc_q <= 4'(cyc_q + 4'h1);
        end
    end

    // Bus clock free-runs at half rate; accesses lock onto its rising edge.
    // It leaves reset low, so it rises on the first edge after reset.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_clock_out <= 1'b0;
        end else begin
            bus_clock_out <= !bus_clock_out;
        end
    end

    // Interface controls follow the next state so they move with the bus clock.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            zone_select_n <= 1'b1;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            read_not_write <= 1'b1;
        end else begin
            // Idle and alignment both leave every control inactive.
            zone_select_n <= !(state_d == EMR_LEAD || state_d == EMR_ACTIVE
                || state_d == EMR_TRAIL);
            read_strobe_n <= (state_d != EMR_ACTIVE);
            write_strobe_n <= 1'b1;
            read_not_write <= 1'b1;
        end
    end

    // Address changes only as an access starts; otherwise the last one holds.
    // Holding it through alignment and idle gives the memory unlimited hold time.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_addr_bus <= EMR_ADDR_RESET;
        end else if (state_d == EMR_LEAD && state_q != EMR_LEAD) begin
            ext_addr_bus <= addr_q;
        end else begin
            ext_addr_bus <= ext_addr_bus;
        end
    end

    // Read data is captured on the last active cycle, as the strobe rises.
    // Ready-off accesses with a nonzero active count capture at the same point; a zero count captures nothing.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= '0;
        end else if (state_q == EMR_ACTIVE && !hold && cyc_q == last_act) begin
            data_q <= data_s;
        end
    end

    // Wait states are counted so software can see how long ready held off.
    // The count saturates rather than wrap, so a stuck ready stays visible.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt_q <= 8'h00;
        end else if (state_q == EMR_IDLE && state_d != EMR_IDLE) begin
            wait_cnt_q <= 8'h00;
        end else if (hold && wait_cnt_q != 8'hFF) begin
            wait_cnt_q <= 8'(wait_cnt_q + 8'h01);
        end
    end

    // Start request; a request while busy waits for the current access to end.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_pend_q <= 1'b0;
        end else if (wr_ctrl && reg_wdata[EMR_CTRL_START_BIT]) begin
            start_pend_q <= 1'b1;
        end else if (state_q == EMR_IDLE && state_d != EMR_IDLE) begin
            start_pend_q <= 1'b0;
        end
    end

    // Done flag; completion in the same cycle as a clear still sets it.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else if (state_q != EMR_IDLE && state_q != EMR_ALIGN && state_d == EMR_IDLE) begin
            done_q <= 1'b1;
        end else if (wr_ctrl && reg_wdata[EMR_CTRL_CLRDONE_BIT]) begin
            done_q <= 1'b0;
        end
    end

    // Configuration and address registers written by software.
    // Changing the configuration mid-access alters that access; software should wait for done.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= emr_cfg_s'(EMR_CFG_RESET);
            addr_q <= EMR_ADDR_RESET;
        end else if (reg_wr) begin
            if (reg_addr == EMR_CFG_OFS) begin
                cfg_q <= emr_cfg_s'(reg_wdata[EMR_CFG_WIDTH-1:0]);
            end
            if (reg_addr == EMR_ADDR_OFS) begin
                addr_q <= reg_wdata[EMR_AW-1:0];
            end
        end
    end

    // Read port; data stands only in the cycle after the strobe.
    // Other cycles read zero, so stale data never looks like a fresh answer.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                EMR_CFG_OFS: begin
                    reg_rdata <= {23'h000000, cfg_q};
                end
                EMR_ADDR_OFS: begin
                    reg_rdata <= {13'h0000, addr_q};
                end
                EMR_STAT_OFS: begin
                    reg_rdata <= {30'h00000000, done_q,
                        (state_q != EMR_IDLE) || start_pend_q};
                end
                EMR_DATA_OFS: begin
                    reg_rdata <= {16'h0000, data_q};
                end
                EMR_WAIT_OFS: begin
                    reg_rdata <= {24'h000000, wait_cnt_q};
                end
                default: begin
                    // Control is write-only; unmapped addresses read zero.
                    reg_rdata <= 32'h00000000;
                end
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule

// ---- testbench/emr_read_seq_sva.sv ----
/*
 * Pin assertions for the external memory read sequencer.
 * Assumes one clock domain in which the core clock is also the timing clock.
 */
`timescale 1ns/1ps
module emr_read_seq_sva (
    input wire logic core_clk, // Core clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic bus_clock_out, // Bus clock.
    input wire logic zone_select_n, // Zone select.
    input wire logic read_strobe_n, // Read strobe.
    input wire logic write_strobe_n, // Write strobe.
    input wire logic read_not_write, // Direction.
    input wire logic [emr_pkg::EMR_AW-1:0] ext_addr_bus // Address bus.
);
    import emr_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    logic [7:0] acc_cnt_q; // Cycles since the access began.
    // Counting from the select edge lets the phase checks work for any wait length.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_cnt_q <= 8'h00;
        end else if (zone_select_n) begin
            acc_cnt_q <= 8'h00;
        end else begin
            acc_cnt_q <= acc_cnt_q + 8'h01;
        end
    end
    // An access opens with select going low as the bus clock rises.
    sequence s_start;
        $fell(zone_select_n) ##0 $rose(bus_clock_out);
    endsequence
    // The strobe rises, then select follows within the trail count.
    sequence s_trail_end;
        ##[0:3] $rose(zone_select_n);
    endsequence
    a_start_edge: assert property ($fell(zone_select_n) |-> s_start)
        else $error("access did not start on a rising bus clock");
    // The first edge out of reset has no earlier toggle to compare with.
    a_clock_free: assert property ($past(rst_n) |->
        bus_clock_out != $past(bus_clock_out))
        else $error("bus clock missed a toggle");
    a_idle_inactive: assert property (zone_select_n |-> read_strobe_n)
        else $error("read strobe active outside an access");
    a_write_off: assert property (write_strobe_n && read_not_write)
        else $error("write controls left their inactive level");
    a_addr_hold: assert property ($changed(ext_addr_bus) |-> s_start)
        else $error("address moved outside an access start");
    a_lead_span: assert property ($fell(read_strobe_n) |->
        !zone_select_n && acc_cnt_q >= 8'h01 && acc_cnt_q <= 8'h03)
        else $error("lead period out of range");
    a_trail_phase: assert property ($rose(read_strobe_n) |->
        bus_clock_out == !acc_cnt_q[0])
        else $error("trail edge on the wrong bus clock phase");
    a_trail_bound: assert property ($rose(read_strobe_n) |-> s_trail_end)
        else $error("select did not end within the trail count");
endmodule

bind emr_read_seq emr_read_seq_sva u_sva (.core_clk(core_clk), .rst_n(rst_n),
    .bus_clock_out(bus_clock_out), .zone_select_n(zone_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .read_not_write(read_not_write), .ext_addr_bus(ext_addr_bus));

// ---- testbench/emr_mem_model.sv ----
/*
 * Behavioural external memory with a ready output.
 * Assumes the core clock and a wait count set by the bench.
 */
`timescale 1ns/1ps
module emr_mem_model (
    input wire logic clk, // Core clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic zone_select_n, // Select from the device.
    input wire logic read_strobe_n, // Strobe from the device.
    input wire logic [18:0] ext_addr_bus, // Address from the device.
    input wire logic [3:0] wait_n, // Strobe cycles before ready rises.
    output logic wait_ready_in, // Ready to the device.
    output logic [15:0] ext_data_in // Data to the device.
);
    logic [3:0] cnt_q; // Strobe-low cycles, saturating.
    logic [15:0] junk_q; // Pattern shown while not read, so stale data never matches.
    // Ready rises after the wait count and drops once select ends.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            wait_ready_in <= 1'b0;
            junk_q <= 16'h0F0F;
        end else begin
            junk_q <= ~junk_q;
            wait_ready_in <= !zone_select_n && (cnt_q >= wait_n);
            if (zone_select_n) begin
                cnt_q <= 4'h0;
            end else if (!read_strobe_n && cnt_q != 4'hF) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
    // Data is valid only while the strobe is low.
    assign ext_data_in = read_strobe_n ? junk_q : (ext_addr_bus[15:0] ^ 16'hA5A5);
endmodule

// ---- testbench/testbench.sv ----
/*
 * Self-checking bench for the read sequencer: register tasks and pin counters.
 * Assumes the memory model and the bound checker stand beside the design.
 */
`timescale 1ns/1ps
module testbench;
    import emr_pkg::*;
    logic core_clk, rst_n, reg_wr, reg_rd, wait_ready_in, bus_clock_out;
    logic zone_select_n, read_strobe_n, write_strobe_n, read_not_write;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv, ws, wa;
    logic [EMR_DW-1:0] ext_data_in;
    logic [EMR_AW-1:0] ext_addr_bus;
    logic [3:0] wait_n;
    int n_mismatch, compares, strobe_low_n, select_low_n;
    emr_read_seq DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .wait_ready_in(wait_ready_in), .ext_data_in(ext_data_in),
        .bus_clock_out(bus_clock_out), .zone_select_n(zone_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .read_not_write(read_not_write), .ext_addr_bus(ext_addr_bus));
    emr_mem_model u_mem (.clk(core_clk), .rst_n(rst_n), .zone_select_n(zone_select_n),
        .read_strobe_n(read_strobe_n), .ext_addr_bus(ext_addr_bus), .wait_n(wait_n),
        .wait_ready_in(wait_ready_in), .ext_data_in(ext_data_in));
    // Clock at 10 MHz.
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Counts the cycles each control spends low, for length checks.
    always @(posedge core_clk) begin
        if (!read_strobe_n) strobe_low_n++;
        if (!zone_select_n) select_low_n++;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h got %0h", name, exp, got);
        end
    endtask
    task automatic final_report;
        if (n_mismatch == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // One read access: configure, start, poll for done, then check data and address.
    task automatic run(input logic [31:0] cfg, input logic [3:0] wn, input logic [18:0] adr,
        input bit skew, output logic [31:0] waits);
        wait_n = wn;
        wr(EMR_CFG_OFS, cfg);
        wr(EMR_ADDR_OFS, {13'h0000, adr});
        strobe_low_n = 0;
        select_low_n = 0;
        // One extra cycle puts the start on the other bus clock phase.
        if (skew) begin
            @(posedge core_clk);
        end
        wr(EMR_CTRL_OFS, 32'h0000_0003);
        rv = 32'h0000_0000;
        for (int i = 0; i < 60 && rv[1] !== 1'b1; i++) rd(EMR_STAT_OFS, rv);
        chk("status", 32'h0000_0002, rv);
        rd(EMR_WAIT_OFS, waits);
        rd(EMR_DATA_OFS, rv);
        chk("data", {16'h0000, adr[15:0] ^ 16'hA5A5}, rv);
        chk("addr_held", {13'h0000, adr}, {13'h0000, ext_addr_bus});
        chk("write_off", 32'h0000_0003, {30'h0, write_strobe_n, read_not_write});
    endtask
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        wait_n = 4'h0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        // Reset values, then the write-only, read-only and unmapped places.
        rd(EMR_CFG_OFS, rv);
        chk("cfg_reset", {23'h000000, EMR_CFG_RESET}, rv);
        // Read data stands one cycle only, then returns to zero.
        @(posedge core_clk);
        #1;
        chk("rdata_drop", 32'h0000_0000, reg_rdata);
        wr(EMR_STAT_OFS, 32'hFFFF_FFFF);
        for (int i = 1; i < 8; i++) begin
            rd(8'(i * 4), rv);
            chk("reset_read", 32'h0000_0000, rv);
        end
        wr(EMR_CFG_OFS, 32'hFFFF_FFFF);
        rd(EMR_CFG_OFS, rv);
        chk("cfg_rw", 32'h0000_01FF, rv);
        // Ready disabled: a slow ready is ignored, only programmed counts run.
        run(32'h0000_002D, 4'hF, 19'h51234, 1'b0, ws);
        chk("waits_off", 32'h0000_0000, ws);
        chk("strobe_off", 32'd3, 32'(strobe_low_n));
        chk("select_off", 32'd5, 32'(select_low_n));
        // Synchronous mode with ready already high, other start phase: no wait state.
        run(32'h0000_00AE, 4'h0, 19'h2BCDE, 1'b1, ws);
        chk("waits_fast", 32'h0000_0000, ws);
        chk("select_fast", 32'd6, 32'(select_low_n));
        // Synchronous mode with a late ready: strobe held for every wait state.
        run(32'h0000_00AE, 4'h8, 19'h6A5A5, 1'b0, ws);
        chk("waits_seen", 32'h0000_0001, 32'(ws > 0));
        chk("strobe_sync", 32'd3 + ws, 32'(strobe_low_n));
        chk("select_sync", 32'd6 + ws, 32'(select_low_n));
        // Asynchronous mode, same ready: first sample two cycles sooner.
        run(32'h0000_01AE, 4'h8, 19'h13579, 1'b0, wa);
        chk("waits_async", ws + 32'd2, wa);
        chk("strobe_async", 32'd3 + wa, 32'(strobe_low_n));
        chk("select_async", 32'd6 + wa, 32'(select_low_n));
        final_report();
    end
    // Cuts a hang short well past the hundred or so cycles the tests need.
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        final_report();
    end
endmodule
